/* File: src/spg_device.sv */
/*
  Board end: pulse generator, board control register, watchdog and the
  quadrature counter reset path. Assumes the host end keeps its own rules
  and that sense pins arrive asynchronously.
*/
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module spg_device
  import spg_pkg::*;
#(
  parameter int WD_LIMIT = WD_CYCLES
) (
  // Clock, reset, enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link.
  spg_link_if.dev link,
  // Sense pins and watchdog jumper.
  input wire logic origin_n_i,
  input wire logic limit_pos_n_i,
  input wire logic limit_neg_n_i,
  input wire logic wd_enable_i,
  // Motor and board outputs.
  output logic step_n_o,
  output logic direction_out_o,
  output logic irq_n_o,
  output logic wd_out_n_o,
  output logic [7:0] board_ctl_o,
  output logic [15:0] quad_count_o
);

  function automatic logic [17:0] put_byte(input logic [17:0] old,
                                           input logic [1:0] lane,
                                           input logic [7:0] b);
    logic [17:0] r;
    r = old;
    if (lane == SEL_B0) begin
      r[7:0] = b;
    end else if (lane == SEL_B1) begin
      r[15:8] = b;
    end else if (lane == SEL_B2) begin
      r[17:16] = b[1:0];
    end
    return r;
  endfunction : put_byte

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] org_s, lp_s, ln_s;
  logic [1:0] wde_s;
  logic [1:0] sel;
  logic wr_act, wr_q, wr_take;
  logic [31:0] wd_cnt;
  logic wd_trip, pg_clear, refresh;
  logic [17:0] ctr;
  logic [12:0] low_spd, high_spd, cur_spd, tgt_spd;
  logic [9:0] ramp_rate, mul, pre_cnt, ramp_cnt;
  logic [15:0] rdp;
  logic [2:0] psel;
  logic [1:0] mode;
  logic hs, stable;
  logic [12:0] acc;
  logic [13:0] next_acc;
  spg_run_t run;
  logic tick, step_ev, sense_stop, end_ev;
  logic [7:0] cmd;

  assign sel = {link.reg_sel_hi, link.reg_sel_lo};
  // Both strobes low is treated as no access at all.
  assign wr_act = !link.cs_n && !link.wr_n && link.rd_n;
  assign wr_take = wr_act && !wr_q;
  assign cmd = link.host_data;
  assign refresh = link.quad_rd || link.ctl_wr;

  // Sense pins cross three flip-flops, the jumper two; the origin edge logic compares the second and third stages.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      org_s <= 3'h7;
      lp_s <= 3'h7;
      ln_s <= 3'h7;
      wde_s <= 2'h0;
      wr_q <= 1'b0;
    end else if (ce_i) begin
      org_s <= {org_s[1:0], origin_n_i};
      lp_s <= {lp_s[1:0], limit_pos_n_i};
      ln_s <= {ln_s[1:0], limit_neg_n_i};
      wde_s <= {wde_s[0], wd_enable_i};
      wr_q <= wr_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Board control register survives bus resets and watchdog trips.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      board_ctl_o <= CTL_RESET;
    end else if (ce_i && link.ctl_wr) begin
      board_ctl_o <= link.host_data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt <= '0;
      wd_out_n_o <= 1'b1;
    end else if (ce_i) begin
      if (refresh || !wde_s[1]) begin
        wd_cnt <= '0;
        wd_out_n_o <= 1'b1;
      end else if (wd_cnt >= 32'(WD_LIMIT - 1)) begin
        wd_out_n_o <= 1'b0;
      end else begin
        wd_cnt <= wd_cnt + 32'h1;
      end
    end
  end

  assign wd_trip = !wd_out_n_o;

  // Watchdog trips never touch the quadrature counter.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      quad_count_o <= '0;
    end else if (ce_i) begin
      if (link.bus_rst || !board_ctl_o[CTL_QRST_N]) begin
        quad_count_o <= '0;
      end
    end
  end

  // Control reset value keeps the generator cleared until the host writes.
  assign pg_clear = link.bus_rst || !board_ctl_o[CTL_PRST_N] || wd_trip;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctr <= CTR_RESET;
      low_spd <= SPEED_RESET;
      high_spd <= SPEED_RESET;
      ramp_rate <= DIV_RESET;
      rdp <= RDP_RESET;
      mul <= DIV_RESET;
      psel <= PR_CTR;
    end else if (ce_i) begin
      if (pg_clear) begin
        ctr <= CTR_RESET;
        low_spd <= SPEED_RESET;
        high_spd <= SPEED_RESET;
        ramp_rate <= DIV_RESET;
        rdp <= RDP_RESET;
        mul <= DIV_RESET;
        psel <= PR_CTR;
      end else if (wr_take && sel == SEL_CMD) begin
        if (cmd[7:4] == OP_SELECT) begin
          psel <= cmd[2:0];
        end
      end else if (wr_take) begin
        unique case (psel)
          PR_CTR: ctr <= put_byte(ctr, sel, cmd);
          PR_LOW: low_spd <= 13'(put_byte({5'h0, low_spd}, sel, cmd));
          PR_HIGH: high_spd <= 13'(put_byte({5'h0, high_spd}, sel, cmd));
          PR_RAMP: ramp_rate <= 10'(put_byte({8'h0, ramp_rate}, sel, cmd));
          PR_RDP: rdp <= 16'(put_byte({2'h0, rdp}, sel, cmd));
          PR_MUL: mul <= 10'(put_byte({8'h0, mul}, sel, cmd));
          default: ;
        endcase
      end else if (step_ev && mode == MODE_PRESET && ctr != '0) begin
        ctr <= ctr - 18'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The prescaler divides by the multiplier; the accumulator adds the
  // current speed each tick and its carry is the step, so the rate is
  // speed/8192 of clock/multiplier.
  assign tick = (pre_cnt >= mul - 10'h1);
  assign next_acc = {1'b0, acc} + {1'b0, cur_spd};
  assign step_ev = run != RUN_IDLE && tick && next_acc[13];
  assign stable = cur_spd == tgt_spd;
  assign sense_stop = direction_out_o ? !lp_s[2] : !ln_s[2];
  always_comb begin
    end_ev = 1'b0;
    if (run != RUN_IDLE) begin
      unique case (mode)
        MODE_PRESET: end_ev = sense_stop || ctr == '0;
        MODE_ORIGIN: end_ev = org_s[2] != org_s[1];
        default: end_ev = sense_stop;
      endcase
      if (run == RUN_DEC && stable) begin
        end_ev = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run <= RUN_IDLE;
      mode <= MODE_CONT;
      hs <= 1'b0;
      direction_out_o <= 1'b0;
      cur_spd <= SPEED_RESET;
      tgt_spd <= SPEED_RESET;
      irq_n_o <= 1'b1;
    end else if (ce_i) begin
      if (pg_clear) begin
        run <= RUN_IDLE;
        mode <= MODE_CONT;
        hs <= 1'b0;
        direction_out_o <= 1'b0;
        cur_spd <= SPEED_RESET;
        tgt_spd <= SPEED_RESET;
        irq_n_o <= 1'b1;
      end else if (wr_take && sel == SEL_CMD && cmd[7:4] != OP_SELECT) begin
        unique case (cmd[7:4])
          OP_START: begin
            run <= RUN_GO;
            mode <= cmd[1:0];
            direction_out_o <= cmd[2];
            hs <= cmd[3];
            cur_spd <= low_spd;
            tgt_spd <= cmd[3] ? high_spd : low_spd;
          end
          OP_STOP: run <= RUN_IDLE;
          OP_STOP_DEC: begin
            run <= (run == RUN_IDLE) ? RUN_IDLE : RUN_DEC;
            tgt_spd <= low_spd;
          end
          OP_SOFT_RST: begin
            run <= RUN_IDLE;
            irq_n_o <= 1'b1;
          end
          default: ;
        endcase
      end else if (end_ev) begin
        run <= RUN_IDLE;
        irq_n_o <= 1'b0;
      end else if (run != RUN_IDLE) begin
        if (hs && mode == MODE_PRESET && {2'h0, rdp} >= ctr) begin
          tgt_spd <= low_spd;
        end
        if (ramp_cnt >= ramp_rate - 10'h1) begin
          if (cur_spd < tgt_spd) begin
            cur_spd <= cur_spd + 13'h1;
          end else if (cur_spd > tgt_spd) begin
            cur_spd <= cur_spd - 13'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
      ramp_cnt <= '0;
      acc <= '0;
      step_n_o <= 1'b1;
    end else if (ce_i) begin
      step_n_o <= !step_ev;
      if (pg_clear || run == RUN_IDLE) begin
        pre_cnt <= '0;
        ramp_cnt <= '0;
        acc <= '0;
      end else begin
        pre_cnt <= tick ? 10'h0 : pre_cnt + 10'h1;
        ramp_cnt <= (ramp_cnt >= ramp_rate - 10'h1) ? 10'h0 :
                    ramp_cnt + 10'h1;
        if (tick) begin
          acc <= next_acc[12:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: the status bytes, the counter and the ramp-down point return data.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.dev_oe <= 1'b0;
      link.dev_data <= 8'h00;
    end else if (ce_i) begin
      link.dev_oe <= !link.cs_n && !link.rd_n && link.wr_n;
      unique case (sel)
        SEL_CMD: link.dev_data <= {irq_n_o, run != RUN_IDLE, stable,
                                   psel == PR_RDP, ctr == '0, !org_s[2],
                                   !lp_s[2], !ln_s[2]};
        SEL_B0: link.dev_data <= psel == PR_RDP ? rdp[7:0] :
                                 psel == PR_CTR ? ctr[7:0] : 8'h00;
        SEL_B1: link.dev_data <= psel == PR_RDP ? rdp[15:8] :
                                 psel == PR_CTR ? ctr[15:8] : 8'h00;
        SEL_B2: link.dev_data <= {!step_n_o, {2'h0, rdp} > ctr,
                                  cur_spd > tgt_spd, cur_spd < tgt_spd,
                                  2'h0, ctr[17:16]};
      endcase
    end
  end

endmodule : spg_device

/* File: src/spg_host.sv */
/*
  Host end: an AXI4-Lite slave that turns command words into parallel port
  cycles and expansion-bus strobes. Assumes one clock shared with the board.
*/
`timescale 1ns/1ns
module spg_host
  import spg_pkg::*;
(
  // Clock, reset, enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // AXI4-Lite slave.
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Link.
  spg_link_if.host link
);

  logic aw_got, w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [1:0] kind;
  logic [7:0] rd_byte;
  logic [1:0] cnt;
  spg_hstate_t hs;
  logic go;

  assign go = aw_got && w_got && !s_axi_bvalid_o && aw_addr == HA_CMD &&
              hs == HS_IDLE && (w_data[13] || w_data[12]);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        s_axi_wready_o <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid_o) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_addr == HA_CMD || aw_addr == HA_STAT) ?
                         RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {16'h0, rd_byte, 7'h0, hs != HS_IDLE};
        s_axi_rresp_o <= s_axi_araddr_i == HA_STAT ? RESP_OKAY :
                         RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One port cycle: setup, strobe for a fixed count, then a hold cycle.
  // Bit 12 set means a bus reset; bit 13 set means a port access.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs <= HS_IDLE;
      cnt <= '0;
      kind <= KIND_PG_WR;
      rd_byte <= 8'h00;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.wr_n <= 1'b1;
      link.reg_sel_hi <= 1'b0;
      link.reg_sel_lo <= 1'b0;
      link.host_data <= 8'h00;
      link.host_oe <= 1'b0;
      link.bus_rst <= 1'b0;
      link.ctl_wr <= 1'b0;
      link.quad_rd <= 1'b0;
    end else if (ce_i) begin
      link.bus_rst <= go && w_data[12];
      link.ctl_wr <= 1'b0;
      link.quad_rd <= 1'b0;
      unique case (hs)
        HS_IDLE: begin
          if (go && w_data[13]) begin
            hs <= HS_SETUP;
            kind <= w_data[11:10];
            link.reg_sel_hi <= w_data[9];
            link.reg_sel_lo <= w_data[8];
            link.host_data <= w_data[7:0];
            link.host_oe <= w_data[11:10] != KIND_PG_RD;
            link.cs_n <= w_data[11];
          end
        end
        HS_SETUP: begin
          hs <= HS_STROBE;
          cnt <= STROBE_CYC;
          // Never both strobes at once.
          link.rd_n <= !(kind == KIND_PG_RD);
          link.wr_n <= !(kind == KIND_PG_WR);
          link.ctl_wr <= kind == KIND_CTL_WR;
          link.quad_rd <= kind == KIND_QUAD_RD;
        end
        HS_STROBE: begin
          cnt <= cnt - 2'h1;
          if (cnt == 2'h1) begin
            hs <= HS_HOLD;
            if (kind == KIND_PG_RD) begin
              rd_byte <= link.dev_data;
            end
            link.rd_n <= 1'b1;
            link.wr_n <= 1'b1;
          end
        end
        HS_HOLD: begin
          hs <= HS_IDLE;
          link.cs_n <= 1'b1;
          link.host_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule : spg_host

/* File: src/spg_link_if.sv */
/*
  Parallel register port plus expansion-bus strobes between host and board.
  Assumes both ends share one clock; each end drives its own data wires.
*/
`timescale 1ns/1ns
interface spg_link_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic reg_sel_hi;
  logic reg_sel_lo;
  logic [7:0] host_data;
  logic host_oe;
  logic [7:0] dev_data;
  logic dev_oe;
  logic bus_rst;
  logic ctl_wr;
  logic quad_rd;

  modport dev (
    input cs_n, rd_n, wr_n, reg_sel_hi, reg_sel_lo, host_data, host_oe,
    input bus_rst, ctl_wr, quad_rd,
    output dev_data, dev_oe
  );
  modport host (
    output cs_n, rd_n, wr_n, reg_sel_hi, reg_sel_lo, host_data, host_oe,
    output bus_rst, ctl_wr, quad_rd,
    input dev_data, dev_oe
  );
endinterface : spg_link_if

/* File: src/spg_pkg.sv */
/*
  Constants and encodings shared by both ends of the
  stepper pulse generator link. Assumes a single 25 MHz clock everywhere.
*/
package spg_pkg;

  // Clock and watchdog timing.
  localparam int CLK_KHZ = 25000;
  localparam int WD_TIME_MS = 1500;
  localparam int WD_CYCLES = WD_TIME_MS * CLK_KHZ;

  // Register-select codes on the parallel port.
  localparam logic [1:0] SEL_CMD = 2'h0;
  localparam logic [1:0] SEL_B0 = 2'h1;
  localparam logic [1:0] SEL_B1 = 2'h2;
  localparam logic [1:0] SEL_B2 = 2'h3;

  // Parameter register indices chosen by the select command.
  localparam logic [2:0] PR_CTR = 3'h0;
  localparam logic [2:0] PR_LOW = 3'h1;
  localparam logic [2:0] PR_HIGH = 3'h2;
  localparam logic [2:0] PR_RAMP = 3'h3;
  localparam logic [2:0] PR_RDP = 3'h4;
  localparam logic [2:0] PR_MUL = 3'h5;

  // Command byte: opcode in [7:4], argument in [3:0].
  localparam logic [3:0] OP_SELECT = 4'h0;
  localparam logic [3:0] OP_START = 4'h1;
  localparam logic [3:0] OP_STOP = 4'h2;
  localparam logic [3:0] OP_STOP_DEC = 4'h3;
  localparam logic [3:0] OP_SOFT_RST = 4'h4;

  // Start argument: [1:0] mode, [2] direction, [3] high speed.
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_PRESET = 2'h1;
  localparam logic [1:0] MODE_ORIGIN = 2'h2;

  // Board control register bits and value after reset.
  localparam int CTL_QRST_N = 0;
  localparam int CTL_PRST_N = 1;
  localparam int CTL_LED_N = 2;
  localparam int CTL_DRV_N = 5;
  localparam int CTL_HSTEP = 6;
  localparam int CTL_WAVE = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Parameter register values after a generator clear.
  localparam logic [17:0] CTR_RESET = 18'h00000;
  localparam logic [12:0] SPEED_RESET = 13'h0001;
  localparam logic [9:0] DIV_RESET = 10'h002;
  localparam logic [15:0] RDP_RESET = 16'h0000;

  // Host engine timing and AXI4-Lite map.
  localparam logic [1:0] STROBE_CYC = 2'h3;
  localparam logic [3:0] HA_CMD = 4'h0;
  localparam logic [3:0] HA_STAT = 4'h4;
  localparam logic [1:0] KIND_PG_WR = 2'h0;
  localparam logic [1:0] KIND_PG_RD = 2'h1;
  localparam logic [1:0] KIND_CTL_WR = 2'h2;
  localparam logic [1:0] KIND_QUAD_RD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_GO = 2'b01,
    RUN_DEC = 2'b11
  } spg_run_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_STROBE = 2'b11,
    HS_HOLD = 2'b10
  } spg_hstate_t;

endpackage : spg_pkg

/* File: tb/spg_link_chk.sv */
/*
  Protocol checker for the parallel port between the host and board ends.
  Assumes one clock and an asynchronous, active high reset.
*/
`timescale 1ns/1ns
module spg_link_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link signals.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_sel_hi,
  input wire logic reg_sel_lo,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic bus_rst,
  input wire logic ctl_wr,
  input wire logic quad_rd
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  deselect_float_a: assert property (cs_n && $past(cs_n) |-> !dev_oe)
    else $error("board drives data while deselected");
  strobe_excl_a: assert property (rd_n || wr_n)
    else $error("both strobes low together");
  read_answer_a: assert property (!cs_n && !rd_n && wr_n |=> dev_oe)
    else $error("board does not answer a read strobe");
  write_len_a: assert property ($fell(wr_n) |-> !wr_n[*3] ##1 wr_n)
    else $error("write strobe length wrong");
  read_len_a: assert property ($fell(rd_n) |-> !rd_n[*3] ##1 rd_n)
    else $error("read strobe length wrong");
  select_setup_a: assert property (($fell(wr_n) || $fell(rd_n)) |->
    !cs_n && !$past(cs_n)) else $error("strobe without select setup");
  write_stable_a: assert property (!cs_n && !$past(cs_n) && host_oe
    |-> $stable({reg_sel_hi, reg_sel_lo, host_data}))
    else $error("write address or data moved");
  ctl_pulse_a: assert property (ctl_wr |-> cs_n ##1 !ctl_wr)
    else $error("control strobe not a single deselected pulse");
  quad_pulse_a: assert property (quad_rd |-> cs_n ##1 !quad_rd)
    else $error("counter read strobe not a single deselected pulse");
  bus_reset_a: assert property (bus_rst |=> !bus_rst)
    else $error("bus reset longer than one cycle");
endmodule : spg_link_chk

/* File: tb/testbench.sv */
/*
  Self-checking bench: AXI4-Lite commands drive the host end, which runs the
  board end over the link. Assumes a 25 MHz clock and the short watchdog.
*/
`timescale 1ns/1ns
module testbench
  import spg_pkg::*;
;
  localparam int WDL = 200;
  typedef struct {logic [33:0] e; logic [33:0] m;} spg_exp_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] aw_addr = 4'h0, ar_addr = 4'h0;
  logic aw_valid = 1'b0, w_valid = 1'b0, ar_valid = 1'b0;
  logic [31:0] w_data = 32'h0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data;
  logic origin_n = 1'b1, lim_pos_n = 1'b1, lim_neg_n = 1'b1, wd_en = 1'b0;
  logic step_n, dir_out, irq_n, wd_n;
  logic [7:0] board_ctl;
  logic [15:0] quad_cnt;
  logic [15:0] rnd = 16'h4ed1;
  int err_total = 0, n_checks = 0, steps = 0;
  spg_exp_t q[$];
  spg_exp_t x;
  always #20 ref_clk_i = ~ref_clk_i;
  spg_link_if link ();
  spg_host i_spg_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid),
    .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data),
    .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid), .s_axi_rready_i(1'b1),
    .link(link));
  spg_device #(.WD_LIMIT(WDL)) i_spg_device (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .link(link), .origin_n_i(origin_n),
    .limit_pos_n_i(lim_pos_n), .limit_neg_n_i(lim_neg_n),
    .wd_enable_i(wd_en), .step_n_o(step_n), .direction_out_o(dir_out),
    .irq_n_o(irq_n), .wd_out_n_o(wd_n), .board_ctl_o(board_ctl),
    .quad_count_o(quad_cnt));
  spg_link_chk i_spg_link_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cs_n(link.cs_n), .rd_n(link.rd_n), .wr_n(link.wr_n),
    .reg_sel_hi(link.reg_sel_hi), .reg_sel_lo(link.reg_sel_lo),
    .host_data(link.host_data), .host_oe(link.host_oe),
    .dev_oe(link.dev_oe), .bus_rst(link.bus_rst), .ctl_wr(link.ctl_wr),
    .quad_rd(link.quad_rd));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [33:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Both readies are held high, so a valid response is always a handshake.
  always @(posedge ref_clk_i) begin
    if (b_valid === 1'b1 || r_valid === 1'b1) begin
      x = q.pop_front();
      chk("axi", (b_valid ? {b_resp, 32'h0} : {r_resp, r_data}) & x.m,
        x.e & x.m);
    end
  end
  always @(posedge ref_clk_i) if (step_n === 1'b0) steps <= steps + 1;
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    q.push_back('{{r, 32'h0}, {2'h3, 32'h0}});
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (aw_ready) aw_valid <= 1'b0;
      if (w_ready) w_valid <= 1'b0;
    end while (b_valid !== 1'b1);
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] v,
                     input logic [33:0] e, m);
    q.push_back('{e, m});
    ar_addr <= a;
    ar_valid <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (ar_ready) ar_valid <= 1'b0;
    end while (r_valid !== 1'b1);
    v = r_data;
  endtask : axr
  task automatic port(input logic [1:0] k, s, input logic [7:0] d);
    logic [31:0] v;
    axw(HA_CMD, {18'h0, 2'b10, k, s, d}, RESP_OKAY);
    v = 32'h1;
    while (v[0] !== 1'b0) axr(HA_STAT, v, {RESP_OKAY, 32'h0}, {2'h3, 32'h0});
  endtask : port
  task automatic pw(input logic [1:0] s, input logic [7:0] d);
    port(KIND_PG_WR, s, d);
  endtask : pw
  task automatic pr(input logic [1:0] s, input logic [7:0] e);
    logic [31:0] v;
    port(KIND_PG_RD, s, 8'h00);
    axr(HA_STAT, v, {RESP_OKAY, 16'h0, e, 8'h0}, {2'h3, 16'h0, 8'hff, 8'h0});
  endtask : pr
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [7:0] n;
    int s0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("ctl", board_ctl, CTL_RESET);
    chk("quad", quad_cnt, 16'h0);
    port(KIND_CTL_WR, SEL_CMD, 8'h03);
    chk("ctl", board_ctl, 8'h03);
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_LOW});
    pw(SEL_B1, 8'h10);
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_MUL});
    pw(SEL_B0, 8'h02);
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_RDP});
    pw(SEL_B0, 8'h02);
    pr(SEL_B0, 8'h02);
    rnd = lfsr(rnd);
    n = 8'(rnd % 16'h7) + 8'h1;
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_CTR});
    pw(SEL_B0, n);
    pr(SEL_B0, n);
    s0 = steps;
    pw(SEL_CMD, {OP_START, 4'b0101});
    for (int i = 0; i < 2000 && irq_n !== 1'b0; i++) @(posedge ref_clk_i);
    chk("preset", steps - s0, n);
    chk("dir", dir_out, 1'b1);
    pr(SEL_B0, 8'h00);
    pw(SEL_CMD, {OP_SOFT_RST, 4'h0});
    chk("irq", irq_n, 1'b1);
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_RDP});
    pr(SEL_B0, 8'h02);
    for (int i = 0; i < 2; i++) begin
      s0 = steps;
      pw(SEL_CMD, {OP_START, 1'b0, i[0], MODE_CONT});
      repeat (60) @(posedge ref_clk_i);
      chk("dir", dir_out, i[0]);
      chk("run", steps > s0, 1'b1);
      pw(SEL_CMD, {i ? OP_STOP_DEC : OP_STOP, 4'h0});
      repeat (30) @(posedge ref_clk_i);
      s0 = steps;
      repeat (60) @(posedge ref_clk_i);
      chk("stop", steps - s0, 0);
    end
    pw(SEL_CMD, {OP_START, 4'b0100});
    repeat (40) @(posedge ref_clk_i);
    lim_pos_n <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    s0 = steps;
    repeat (60) @(posedge ref_clk_i);
    chk("limit", steps - s0, 0);
    lim_pos_n <= 1'b1;
    pw(SEL_CMD, {OP_START, 4'b0110});
    repeat (40) @(posedge ref_clk_i);
    origin_n <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    origin_n <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    s0 = steps;
    repeat (60) @(posedge ref_clk_i);
    chk("origin", steps - s0, 0);
    port(KIND_CTL_WR, SEL_CMD, 8'h01);
    port(KIND_CTL_WR, SEL_CMD, 8'h03);
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_RDP});
    pr(SEL_B0, RDP_RESET[7:0]);
    pw(SEL_B0, 8'h02);
    axw(HA_CMD, 32'h00001000, RESP_OKAY);
    repeat (4) @(posedge ref_clk_i);
    chk("ctl", board_ctl, 8'h03);
    pw(SEL_CMD, {OP_SELECT, 1'b0, PR_RDP});
    pr(SEL_B0, 8'h00);
    wd_en <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      repeat (WDL + 50) @(posedge ref_clk_i);
      chk("wdog", wd_n, 1'b0);
      port(i ? KIND_CTL_WR : KIND_QUAD_RD, SEL_CMD, 8'h03);
      chk("wdog", wd_n, 1'b1);
      chk("quad", quad_cnt, 16'h0);
    end
    wd_en <= 1'b0;
    axw(4'h8, 32'h0, RESP_SLVERR);
    axr(4'hc, v, {RESP_SLVERR, 32'h0}, {2'h3, 32'h0});
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    print_verdict();
  end
endmodule : testbench
